// [ssre_top.sv]
// Purpose: Encodes replies to state and increment queries of the serial protocol.
// Assumes: Queries come from a parser on the same clock; state inputs likewise.
// Notes: Replies leave as a byte stream framed by a lead character and a carriage return.
// Notes on behaviour
// - In wait-for-disable, run, init or disable state the state reply names that state.
// - In a system error the state reply marks a system error and carries its fault code.
// - In a motor error the state reply names the failed motor and carries its fault code.
// - System codes 2 to 5 mean power supply low, power high, signal low, signal high.
// - System code 6 means overheated or faulty and code 7 means internal 12V missing.
// - Motor codes 1 to 4 mean overload, overheat, following error and missing slider.
// - Motor codes 6, 7 and 8 mean init failed, wrong or bad motor, bad profile; 5 unused.
// - Motor codes 9, 10 and 11 mean board overcurrent, overtemperature and blown fuse.
// - Position step is 19.53125 um linear, 1/8 step stepper, 23.438 mA solenoid.
// - Speed step is 190.735 um/s linear, 0.081469 steps/s stepper, zero solenoid.
// - Acceleration step is 238.419 mm/s2 linear, 47.6836 steps/s2 stepper, none else.
// - Current step is 23.438 mA.
// - On a multidrop link controller ID n owns the four letters from A plus 4(n-1).
// - In point-to-point mode only ID 1 and motors A to D pass, else a wrong-selection error.
`timescale 1ns/1ps
`include "ssre_defines.svh"
module ssre_top
	import ssre_pkg::*;
(
	input  wire logic        clk,        // 20 MHz clock.
	input  wire logic        nrst,       // Asynchronous reset, active low.
	input  wire logic        req,        // Query strobe, one cycle.
	input  wire ssre_query_t req_kind,   // Which query.
	input  wire logic [2:0]  req_id,     // Addressed controller ID.
	input  wire logic [7:0]  req_letter, // Addressed motor letter, ASCII.
	input  wire logic [2:0]  own_id,     // This controller's ID.
	input  wire logic        multidrop,  // High on a multidrop link.
	input  wire ssre_ctl_t   ctl_state,  // Operating state.
	input  wire logic [1:0]  err_motor,  // Failed motor, 0 is the first.
	input  wire logic [3:0]  sys_code,   // System fault code.
	input  wire logic [3:0]  mot_code,   // Motor fault code.
	input  wire logic [7:0]  mtype,      // Two bits of motor type per motor.
	input  wire logic        tx_ready,   // Sink takes tx_data.
	output logic      [7:0]  tx_data,    // Reply character.
	output logic             tx_valid,   // Reply character valid.
	output logic             busy,       // Reply in progress.
	output logic             sel_err     // Wrong selection pulse.
);

	ssre_rom_if rom_bus ();

	ssre_rom u_rom (
		.clk  (clk),
		.nrst (nrst),
		.rom  (rom_bus.mem)
	);

	ssre_fsm_t  state_r,  state_nxt;
	logic [3:0] idx_r,    idx_nxt;
	logic [2:0] len_r,    len_nxt;
	logic [7:0] buf_r     [4];
	logic [7:0] buf_nxt   [4];
	logic       rom_r,    rom_nxt;
	logic [3:0] str_r,    str_nxt;
	logic [7:0] tx_data_r, tx_data_nxt;
	logic       tx_valid_r, tx_valid_nxt;
	logic       busy_r,   busy_nxt;
	logic       sel_err_r, sel_err_nxt;

	// Letter of motor m on controller id; ID 1 starts at A.
	function automatic logic [7:0] letter_of(input logic [2:0] id, input logic [1:0] m);
		letter_of = `SSRE_CH_A + {3'h0, id - 3'h1, m};
	endfunction : letter_of

	// Fault codes as one or two ASCII digits, left aligned; returns the count in [1:0].
	function automatic logic [17:0] digits_of(input logic [3:0] c);
		if (c >= 4'hA) begin
			digits_of = {`SSRE_CH_ONE, `SSRE_CH_ZERO + {4'h0, c - 4'hA}, 2'h2};
		end else begin
			digits_of = {`SSRE_CH_ZERO + {4'h0, c}, 8'h00, 2'h1};
		end
	endfunction : digits_of

	logic        hit;
	logic        addr_ok;
	logic [1:0]  mot_idx;
	logic [7:0]  body_ch;
	logic        body_done;
	logic        tx_free;
	logic [17:0] dig;
	logic [1:0]  mt;

	always_comb begin
		mot_idx = 2'(req_letter - letter_of(multidrop ? own_id : `SSRE_P2P_ID, 2'h0));
		if (multidrop) begin
			hit     = (req_id == own_id);
			addr_ok = (req_letter >= letter_of(own_id, 2'h0))
				&& (req_letter <= letter_of(own_id, 2'h3));
		end else begin
			hit     = 1'b1;
			addr_ok = (req_id == `SSRE_P2P_ID) && (req_letter >= `SSRE_CH_A)
				&& (req_letter <= `SSRE_CH_D);
		end
		mt        = mtype[mot_idx * 2 +: 2];
		tx_free   = !tx_valid_r || tx_ready;
		body_ch   = rom_r ? rom_bus.data : buf_r[idx_r[1:0]];
		body_done = rom_r ? (idx_r == `SSRE_STR_LEN || rom_bus.data == 8'h00)
			: (idx_r[2:0] == len_r);
		dig       = digits_of(ctl_state == SSRE_C_ERR_SYS ? sys_code : mot_code);
	end

	assign rom_bus.str = str_r;
	assign rom_bus.idx = idx_r[2:0];

	always_comb begin
		state_nxt    = state_r;
		idx_nxt      = idx_r;
		len_nxt      = len_r;
		buf_nxt      = buf_r;
		rom_nxt      = rom_r;
		str_nxt      = str_r;
		tx_data_nxt  = tx_data_r;
		tx_valid_nxt = tx_valid_r && !tx_ready;
		sel_err_nxt  = 1'b0;
		unique case (state_r)
			SSRE_S_IDLE: begin
				if (req && hit) begin
					state_nxt = SSRE_S_LEAD;
					rom_nxt   = 1'b0;
					if (!addr_ok) begin
						buf_nxt     = '{`SSRE_CH_E, `SSRE_CH_FIVE, `SSRE_CH_SIX, 8'h00};
						len_nxt     = 3'h3;
						sel_err_nxt = 1'b1;
					end else if (req_kind == SSRE_Q_STATE) begin
						len_nxt = 3'h1;
						buf_nxt = '{8'h00, 8'h00, 8'h00, 8'h00};
						unique case (ctl_state)
							SSRE_C_WAIT:    buf_nxt[0] = `SSRE_CH_WAIT;
							SSRE_C_RUN:     buf_nxt[0] = `SSRE_CH_RUN;
							SSRE_C_INIT:    buf_nxt[0] = `SSRE_CH_INIT;
							SSRE_C_DISABLE: buf_nxt[0] = `SSRE_CH_DIS;
							SSRE_C_ERR_SYS: begin
								// Codes 2 to 7 pass through as digits
								buf_nxt = '{`SSRE_CH_E, `SSRE_CH_S, dig[17:10], dig[9:2]};
								len_nxt = 3'h2 + {1'b0, dig[1:0]};
							end
							SSRE_C_ERR_MOT: begin
								// Codes 1 to 11 pass through as digits
								buf_nxt = '{`SSRE_CH_E,
									letter_of(multidrop ? own_id : `SSRE_P2P_ID, err_motor),
									dig[17:10], dig[9:2]};
								len_nxt = 3'h2 + {1'b0, dig[1:0]};
							end
							default: buf_nxt[0] = `SSRE_CH_E;
						endcase
					end else begin
						rom_nxt = 1'b1;
						// Motors without a type report like solenoids.
						unique case (req_kind)
							SSRE_Q_POS: str_nxt = `SSRE_STR_POS + {2'h0, mt[1] ? 2'h2 : mt};
							SSRE_Q_SPD: str_nxt = `SSRE_STR_SPD + {2'h0, mt[1] ? 2'h2 : mt};
							SSRE_Q_ACC: str_nxt = `SSRE_STR_ACC + {2'h0, mt[1] ? 2'h2 : mt};
							default:    str_nxt = `SSRE_STR_CUR;
						endcase
					end
				end
			end
			SSRE_S_LEAD: begin
				if (tx_free) begin
					tx_data_nxt  = `SSRE_CH_LEAD;
					tx_valid_nxt = 1'b1;
					idx_nxt      = 4'h0;
					state_nxt    = SSRE_S_FETCH;
				end
			end
			SSRE_S_FETCH: begin
				// One cycle lets the registered memory output settle on idx_r.
				state_nxt = SSRE_S_BODY;
			end
			SSRE_S_BODY: begin
				if (body_done) begin
					state_nxt = SSRE_S_TAIL;
				end else if (tx_free) begin
					tx_data_nxt  = body_ch;
					tx_valid_nxt = 1'b1;
					idx_nxt      = idx_r + 4'h1;
					state_nxt    = SSRE_S_FETCH;
				end
			end
			SSRE_S_TAIL: begin
				if (tx_free) begin
					tx_data_nxt  = `SSRE_CH_END;
					tx_valid_nxt = 1'b1;
					state_nxt    = SSRE_S_IDLE;
				end
			end
			default: state_nxt = SSRE_S_IDLE;
		endcase
		busy_nxt = (state_nxt != SSRE_S_IDLE);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r    <= SSRE_S_IDLE;
			idx_r      <= 4'h0;
			len_r      <= 3'h0;
			buf_r      <= '{8'h00, 8'h00, 8'h00, 8'h00};
			rom_r      <= 1'b0;
			str_r      <= 4'h0;
			tx_data_r  <= 8'h00;
			tx_valid_r <= 1'b0;
			busy_r     <= 1'b0;
			sel_err_r  <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			idx_r      <= idx_nxt;
			len_r      <= len_nxt;
			buf_r      <= buf_nxt;
			rom_r      <= rom_nxt;
			str_r      <= str_nxt;
			tx_data_r  <= tx_data_nxt;
			tx_valid_r <= tx_valid_nxt;
			busy_r     <= busy_nxt;
			sel_err_r  <= sel_err_nxt;
		end
	end

	assign tx_data  = tx_data_r;
	assign tx_valid = tx_valid_r;
	assign busy     = busy_r;
	assign sel_err  = sel_err_r;

endmodule : ssre_top

// [ssre_defines.svh]
// Purpose: Constants of the servo status reply encoder.
// Assumes: Included by its bare name.
// Notes: ASCII characters of the reply frame, controller IDs and text memory string indices.
`ifndef SSRE_DEFINES_SVH
`define SSRE_DEFINES_SVH

`define SSRE_CH_LEAD   8'h23
`define SSRE_CH_END    8'h0D
`define SSRE_CH_ZERO   8'h30
`define SSRE_CH_ONE    8'h31
`define SSRE_CH_A      8'h41
`define SSRE_CH_D      8'h44
`define SSRE_CH_E      8'h45
`define SSRE_CH_S      8'h53
`define SSRE_CH_WAIT   8'h57
`define SSRE_CH_RUN    8'h52
`define SSRE_CH_INIT   8'h49
`define SSRE_CH_DIS    8'h44
`define SSRE_CH_FIVE   8'h35
`define SSRE_CH_SIX    8'h36
`define SSRE_P2P_ID    3'h1
`define SSRE_MAX_ID    3'h6
`define SSRE_STR_LEN   4'h8
`define SSRE_STR_POS   4'h0
`define SSRE_STR_SPD   4'h3
`define SSRE_STR_ACC   4'h6
`define SSRE_STR_CUR   4'h9

`endif

// [ssre_pkg.sv]
// Purpose: Types of the servo status reply encoder.
// Assumes: Shared by the top module and the text memory.
// Notes: Codes of the query and state enums are chosen for this block.
package ssre_pkg;

	typedef enum logic [2:0] {
		SSRE_Q_STATE = 3'h0,
		SSRE_Q_POS   = 3'h1,
		SSRE_Q_SPD   = 3'h2,
		SSRE_Q_ACC   = 3'h3,
		SSRE_Q_CUR   = 3'h4
	} ssre_query_t;

	typedef enum logic [2:0] {
		SSRE_C_WAIT    = 3'h0,
		SSRE_C_RUN     = 3'h1,
		SSRE_C_INIT    = 3'h2,
		SSRE_C_DISABLE = 3'h3,
		SSRE_C_ERR_SYS = 3'h4,
		SSRE_C_ERR_MOT = 3'h5
	} ssre_ctl_t;

	typedef enum logic [1:0] {
		SSRE_M_LINEAR   = 2'h0,
		SSRE_M_STEPPER  = 2'h1,
		SSRE_M_SOLENOID = 2'h2,
		SSRE_M_NONE     = 2'h3
	} ssre_mtype_t;

	typedef enum logic [2:0] {
		SSRE_S_IDLE  = 3'b000,
		SSRE_S_LEAD  = 3'b001,
		SSRE_S_FETCH = 3'b011,
		SSRE_S_BODY  = 3'b010,
		SSRE_S_TAIL  = 3'b110
	} ssre_fsm_t;

endpackage : ssre_pkg

// [ssre_rom_if.sv]
// Purpose: Carrier between the encoder and its text memory.
// Assumes: One clock; read data lag the address by one cycle.
// Notes: Address is string index and character index.
`timescale 1ns/1ps
interface ssre_rom_if;
	logic [3:0] str;
	logic [2:0] idx;
	logic [7:0] data;
	modport user (output str, output idx, input data);
	modport mem  (input str, input idx, output data);
endinterface : ssre_rom_if

// [ssre_rom.sv]
// Purpose: Text memory holding the increment replies as ASCII strings.
// Assumes: Strings are left aligned, eight characters, zero padded.
// Notes: Read data come out of a register, one cycle after the address.
`timescale 1ns/1ps
module ssre_rom
	import ssre_pkg::*;
(
	input  wire logic clk,  // Clock.
	input  wire logic nrst, // Asynchronous reset, active low.
	ssre_rom_if.mem   rom   // Address in, registered character out.
);

	logic [7:0]  data_r;
	logic [7:0]  data_nxt;
	logic [63:0] str_text;

	function automatic logic [63:0] text_of(input logic [3:0] s);
		unique case (s)
			4'h0:    text_of = "19.53125";
			4'h1:    text_of = {"0.125", 24'h0};
			4'h2:    text_of = {"23.438", 16'h0};
			4'h3:    text_of = {"190.735", 8'h0};
			4'h4:    text_of = "0.081469";
			4'h5:    text_of = {"0", 56'h0};
			4'h6:    text_of = {"238.419", 8'h0};
			4'h7:    text_of = {"47.6836", 8'h0};
			4'h8:    text_of = {"-", 56'h0};
			4'h9:    text_of = {"23.438", 16'h0};
			default: text_of = 64'h0;
		endcase
	endfunction : text_of

	// The whole string is held in a variable first, since a function result takes no select.
	always_comb begin
		str_text = text_of(rom.str);
		data_nxt = str_text[(3'h7 - rom.idx) * 8 +: 8];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			data_r <= 8'h00;
		end else begin
			data_r <= data_nxt;
		end
	end

	assign rom.data = data_r;

endmodule : ssre_rom

// [ssre_checker.sv]
// Purpose: Port assertions of the servo status reply encoder.
// Assumes: One clock; nrst asynchronous, active low.
// Notes: Bound to ssre_top below the module.
`timescale 1ns/1ps
module ssre_checker
	import ssre_pkg::*;
(
	input wire logic        clk,        // Clock.
	input wire logic        nrst,       // Reset, active low.
	input wire logic        req,        // Query strobe.
	input wire ssre_query_t req_kind,   // Query kind.
	input wire logic [2:0]  req_id,     // Addressed ID.
	input wire logic [7:0]  req_letter, // Addressed letter.
	input wire logic [2:0]  own_id,     // Own ID.
	input wire logic        multidrop,  // Link mode.
	input wire logic        tx_ready,   // Sink ready.
	input wire logic [7:0]  tx_data,    // Reply character.
	input wire logic        tx_valid,   // Character valid.
	input wire logic        busy,       // Reply running.
	input wire logic        sel_err     // Wrong selection.
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic take;
	logic bad_p2p;
	assign take = req && !busy && (!multidrop || req_id == own_id);
	assign bad_p2p = req_id != 3'h1 || req_letter < 8'h41 || req_letter > 8'h44;
	sequence lead_out; tx_valid && tx_data == 8'h23; endsequence
	sequence frame_end; tx_valid && tx_data == 8'h0D; endsequence
	sequence cur_digit; tx_valid && tx_data == 8'h32; endsequence
	take_busy_a: assert property (take |=> busy)
		else $error("reply did not start");
	miss_ignore_a: assert property (req && !busy && multidrop && req_id != own_id |=> !busy)
		else $error("foreign ID answered");
	bad_sel_a: assert property (take && !multidrop && bad_p2p |=> sel_err)
		else $error("bad address passed");
	good_sel_a: assert property (take && !multidrop && !bad_p2p |=> !sel_err)
		else $error("good address refused");
	sel_pulse_a: assert property (sel_err |=> !sel_err)
		else $error("selection error too long");
	hold_char_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("character dropped");
	lead_char_a: assert property ($rose(busy) |-> ##[1:3] lead_out)
		else $error("lead character missing");
	end_char_a: assert property ($fell(busy) |-> frame_end)
		else $error("frame end missing");
	// A stalled character may be handed over while the next one loads, so only a fresh one counts.
	fetch_gap_a: assert property ($rose(tx_valid) && busy && tx_ready |=> !tx_valid)
		else $error("no fetch cycle");
	cur_first_a: assert property (take && !multidrop && !bad_p2p && req_kind == SSRE_Q_CUR
		|-> ##[2:20] cur_digit)
		else $error("current step reply wrong");
endmodule : ssre_checker
bind ssre_top ssre_checker chk (.clk, .nrst, .req, .req_kind, .req_id, .req_letter, .own_id,
	.multidrop, .tx_ready, .tx_data, .tx_valid, .busy, .sel_err);

// [ssre_sink.sv]
// Purpose: Byte sink standing for the serial transmitter.
// Assumes: Takes a character when tx_valid and tx_ready meet at an edge.
// Notes: In slow mode ready drops half the time, so characters must wait.
`timescale 1ns/1ps
module ssre_sink (
	input  wire logic       clk,      // Clock.
	input  wire logic       nrst,     // Reset, active low.
	input  wire logic [7:0] tx_data,  // Character.
	input  wire logic       tx_valid, // Character valid.
	input  wire logic       slow,     // Stall often.
	output logic            tx_ready  // Ready.
);
	logic [7:0] got_q[$];
	logic [2:0] cnt_r;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 3'h0;
			tx_ready <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
			if (tx_valid && tx_ready)
				got_q.push_back(tx_data);
			tx_ready <= !slow || cnt_r[1];
		end
	end
endmodule : ssre_sink

// [ssre_tb_top.sv]
// Purpose: Self-checking bench of the servo status reply encoder.
// Assumes: 20 MHz clock; replies are read back from the sink.
// Notes: Random queries from an LFSR seeded at 8, plus corner cases.
`timescale 1ns/1ps
module ssre_tb_top;
	import ssre_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, req = 1'b0, multidrop = 1'b0, slow = 1'b0;
	logic [2:0] req_id = 3'h1, own_id = 3'h1;
	logic [7:0] req_letter = 8'h41, mtype = 8'h00, seed = 8'h08, tx_data;
	logic [1:0] err_motor = 2'h0;
	logic [3:0] sys_code = 4'h2, mot_code = 4'h1;
	ssre_query_t req_kind = SSRE_Q_STATE;
	ssre_ctl_t ctl_state = SSRE_C_WAIT;
	logic tx_ready, tx_valid, busy, sel_err;
	int n_fail = 0, tests_run = 0, cyc = 0;
	string st_t[4] = '{"W", "R", "I", "D"};
	string pos_t[4] = '{"19.53125", "0.125", "23.438", "23.438"};
	string spd_t[4] = '{"190.735", "0.081469", "0", "0"};
	string acc_t[4] = '{"238.419", "47.6836", "-", "-"};
	ssre_top dut (.clk, .nrst, .req, .req_kind, .req_id, .req_letter, .own_id, .multidrop,
		.ctl_state, .err_motor, .sys_code, .mot_code, .mtype, .tx_ready, .tx_data,
		.tx_valid, .busy, .sel_err);
	ssre_sink sink (.clk, .nrst, .tx_data, .tx_valid, .slow, .tx_ready);
	always #25 clk = !clk;
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr
	function automatic string body();
		logic [7:0] base;
		logic [1:0] mt;
		base = multidrop ? 8'h41 + 8'({own_id - 3'h1, 2'h0}) : 8'h41;
		mt = mtype[{req_letter[1:0] - 2'h1, 1'b0} +: 2];
		if ((!multidrop && req_id != 3'h1) || req_letter < base || req_letter > base + 8'h3)
			return "E56";
		case (req_kind)
			SSRE_Q_POS: return pos_t[mt];
			SSRE_Q_SPD: return spd_t[mt];
			SSRE_Q_ACC: return acc_t[mt];
			SSRE_Q_CUR: return "23.438";
			default: ;
		endcase
		if (ctl_state < SSRE_C_ERR_SYS)
			return st_t[ctl_state[1:0]];
		if (ctl_state == SSRE_C_ERR_SYS)
			return $sformatf("ES%0d", sys_code);
		return $sformatf("E%c%0d", base + 8'(err_motor), mot_code);
	endfunction : body
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	task automatic go(input logic hit);
		string got, want;
		int i;
		@(posedge clk);
		sink.got_q.delete();
		req <= 1'b1;
		want = hit ? {"#", body(), "\015"} : "";
		@(posedge clk);
		req <= 1'b0;
		for (i = 0; i < (hit ? 400 : 8) && !(sink.got_q.size() > 0 && sink.got_q[$] === 8'h0D); i++)
			@(posedge clk);
		got = "";
		foreach (sink.got_q[j])
			got = $sformatf("%s%c", got, sink.got_q[j]);
		tests_run++;
		if (got != want) begin
			n_fail++;
			$display("FAIL reply expected %s seen %s", want, got);
		end
	endtask : go
	task automatic rnd();
		logic [2:0] oid;
		logic md;
		logic far;
		seed = lfsr(seed);
		oid = 3'h1 + 3'(seed % 6);
		md = seed[6];
		far = seed[7];
		own_id <= oid;
		multidrop <= md;
		req_id <= far ? oid + 3'h1 : (md ? oid : 3'h1);
		req_kind <= ssre_query_t'(seed % 5);
		seed = lfsr(seed);
		req_letter <= (md ? 8'h40 + 8'({oid - 3'h1, 2'h0}) : 8'h40) + 8'(seed % 6);
		ctl_state <= ssre_ctl_t'(seed % 6);
		err_motor <= seed[7:6];
		slow <= seed[3];
		seed = lfsr(seed);
		mtype <= seed;
		sys_code <= 4'h2 + 4'(seed % 6);
		mot_code <= 4'(seed % 10) + ((seed % 10) > 3 ? 4'h2 : 4'h1);
		// A foreign ID on a multidrop link gets no reply; point-to-point always answers.
		go(!md || !far);
	endtask : rnd
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		tests_run++;
		if (busy !== 1'b0 || tx_valid !== 1'b0 || sel_err !== 1'b0) begin
			n_fail++;
			$display("FAIL reset outputs expected 0 seen %b%b%b", busy, tx_valid, sel_err);
		end
		for (int c = 0; c < 6; c++) begin
			ctl_state <= ssre_ctl_t'(c);
			mot_code <= 4'h9 + 4'(c % 3);
			sys_code <= 4'h2 + 4'(c);
			go(1'b1);
		end
		for (int k = 1; k < 5; k++)
			for (int m = 0; m < 4; m++) begin
				req_kind <= ssre_query_t'(k);
				mtype <= {4{2'(m)}};
				go(1'b1);
			end
		req_kind <= SSRE_Q_STATE;
		req_letter <= 8'h45;
		go(1'b1);
		repeat (120) rnd();
		test_done();
	end
endmodule : ssre_tb_top
